/* verilog/cvrd_pkg.sv */
// package: timing, reference codes and states for the charger request decoder
`default_nettype none
package cvrd_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int CNT_W = 27;
  // filter and timing figures in their own units
  localparam int unsigned DETECT_DONE_FILTER_MS = 1250;
  localparam int unsigned MINUS_LINE_LOW_FILTER_US = 2500;
  localparam int unsigned VOLTAGE_CHANGE_FILTER_MS = 40;
  localparam int unsigned PLUS_LINE_LOW_FILTER_MS = 50;
  localparam int unsigned STEP_PULSE_FILTER_US = 150;
  // derived cycle counts
  localparam int unsigned DETECT_DONE_CYC = DETECT_DONE_FILTER_MS * (CLK_HZ / 1000);
  localparam int unsigned MINUS_LOW_CYC = MINUS_LINE_LOW_FILTER_US * (CLK_HZ / 1_000_000);
  localparam int unsigned VCHANGE_CYC = VOLTAGE_CHANGE_FILTER_MS * (CLK_HZ / 1000);
  localparam int unsigned PLUS_LOW_CYC = PLUS_LINE_LOW_FILTER_MS * (CLK_HZ / 1000);
  localparam int unsigned STEP_PULSE_CYC = STEP_PULSE_FILTER_US * (CLK_HZ / 1_000_000);
  // voltage loop reference in 0.2 V units (one unit is one output step)
  localparam int REF_W = 7;
  localparam logic [REF_W-1:0] REF_STEP = 7'h01;
  localparam logic [REF_W-1:0] REF_5V = 7'h19;
  localparam logic [REF_W-1:0] REF_9V = 7'h2d;
  localparam logic [REF_W-1:0] REF_12V = 7'h3c;
  localparam logic [REF_W-1:0] REF_MIN = 7'h12;
  localparam logic [REF_W-1:0] REF_MAX = REF_12V;
  // current loop reference selection
  typedef enum logic [1:0] {CUR_5V, CUR_9V, CUR_12V} cvrd_cur_t;
  // decoded line request
  typedef enum logic [2:0] {REQ_5V, REQ_9V, REQ_12V, REQ_CONT, REQ_HOLD} cvrd_req_t;
  typedef enum logic [1:0] {ST_PLAIN, ST_WAIT_DM, ST_HV} cvrd_state_t;
endpackage : cvrd_pkg
`default_nettype wire

/* verilog/cvrd_filter.sv */
// glitch filter: output follows the input once it has held steady for LIMIT cycles
`timescale 1ns/100ps
`default_nettype none
module cvrd_filter
  import cvrd_pkg::*;
#(
  parameter logic [CNT_W-1:0] LIMIT = 27'h0000001
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic raw,
  output logic filt
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic next_filt;

  // counter runs only while raw disagrees; any bounce back restarts it
  always_comb begin
    next_cnt = '0;
    next_filt = filt;
    if (raw != filt) begin
      if (cnt >= LIMIT - 27'h0000001) begin
        next_filt = raw;
      end else begin
        next_cnt = cnt + 27'h0000001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt <= '0;
      filt <= 1'b0;
    end else begin
      cnt <= next_cnt;
      filt <= next_filt;
    end
  end
endmodule : cvrd_filter
`default_nettype wire

/* verilog/cvrd_decoder.sv */
// charger voltage request decoder: handshake, line decode, stepping and discharge
// Function
// - default 5V voltage and current references
// - finish handshake before decoding line levels
// - map 0.6/0.6 12V, 3.3/0.6 9V, 0.6/3.3 continuous
// - short plus to minus in plain port mode
// - detection done after plus above data level 1.25 s
// - minus low recognised after 2.5 ms
// - open short within 10 ms of acceptance
// - plus low acted on after 50 ms
// - fixed request applied after 40 ms stable
// - continuous pulses filtered 100 to 200 us
// - discharge while output above 102 percent reference
// - enable discharge sink on downward switch
// - plus at ground returns 5V, resets handshake
// - continuous step is 0.2 V reference
`timescale 1ns/100ps
`default_nettype none
module cvrd_decoder
  import cvrd_pkg::*;
#(
  parameter int unsigned DETECT_CYCLES = DETECT_DONE_CYC,
  parameter int unsigned MINUS_LOW_CYCLES = MINUS_LOW_CYC,
  parameter int unsigned VCHANGE_CYCLES = VCHANGE_CYC,
  parameter int unsigned PLUS_LOW_CYCLES = PLUS_LOW_CYC,
  parameter int unsigned STEP_CYCLES = STEP_PULSE_CYC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic plus_data, // d+ above data detect level
  input wire logic plus_high, // d+ above selection level
  input wire logic minus_data, // d- above data detect level
  input wire logic minus_high, // d- above selection level
  input wire logic output_above_ref, // sensed output above 102 percent of reference
  output logic line_short, // d+ to d- low-resistance switch
  output logic [REF_W-1:0] voltage_loop_reference,
  output cvrd_cur_t current_loop_reference,
  output logic output_discharge,
  output logic high_voltage_port_mode,
  output logic continuous_mode
);
  // filtered line levels; the _d copies are one cycle late for edge detection
  logic plus_up_f, plus_gnd_f, minus_low_f, step_up_f, step_dn_f;
  logic step_up_d, step_dn_d;
  // detection filter clear: any d+ drop restarts the full detection time
  logic det_clr;
  // handshake progress and the request that is being timed
  cvrd_state_t state, next_state;
  cvrd_req_t req_raw, req_last, next_req_last;
  logic [CNT_W-1:0] req_cnt, next_req_cnt;
  // next values of the registered outputs
  logic [REF_W-1:0] next_ref;
  cvrd_cur_t next_cur;
  logic next_short, next_dis, next_hv, next_cont, dis_armed, next_armed;

  // the detection filter would otherwise keep its high output through a short
  // d+ ground, so a reset handshake would skip the detection wait on return
  assign det_clr = sys_rst || !plus_data;

  // d+ held at data level completes charger detection
  // only read in the plain state, so clearing it on a d+ dip costs nothing later
  cvrd_filter #(.LIMIT(CNT_W'(DETECT_CYCLES))) u_det (
    .sys_clk(sys_clk), .sys_rst(det_clr), .raw(plus_data), .filt(plus_up_f));
  // d+ at ground must persist before the handshake is dropped
  // the long filter tells an unplug or partner reset from line noise
  cvrd_filter #(.LIMIT(CNT_W'(PLUS_LOW_CYCLES))) u_plow (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .raw(!plus_data), .filt(plus_gnd_f));
  // d- at ground with the switch open is the partner's answer to detection
  cvrd_filter #(.LIMIT(CNT_W'(MINUS_LOW_CYCLES))) u_mlow (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .raw(!minus_data), .filt(minus_low_f));
  // step pulses: d+ raised to 3.3 steps up, d- dropped from 3.3 steps down
  // a down pulse shows 0.6/0.6, the 12V pair; it ends long before the request
  // filter runs out, so it never settles as a fixed request
  cvrd_filter #(.LIMIT(CNT_W'(STEP_CYCLES))) u_sup (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .raw(plus_high), .filt(step_up_f));
  cvrd_filter #(.LIMIT(CNT_W'(STEP_CYCLES))) u_sdn (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .raw(plus_data && minus_data && !minus_high),
    .filt(step_dn_f));

  // levels: data means above the detect level, high means near 3.3 V
  // level decode; unlisted pairs keep the previous voltage
  always_comb begin
    req_raw = REQ_HOLD;
    if (plus_data && !plus_high && minus_data && !minus_high) begin
      req_raw = REQ_12V;
    end else if (plus_high && minus_data && !minus_high) begin
      req_raw = REQ_9V;
    end else if (plus_data && !plus_high && minus_high) begin
      req_raw = REQ_CONT;
    end else if (plus_data && !plus_high && !minus_data) begin
      req_raw = REQ_5V;
    end
  end

  // current limit follows the band the voltage reference sits in
  // taken from the reference itself, so stepping moves the limit as well
  function automatic cvrd_cur_t cur_for(input logic [REF_W-1:0] r);
    if (r > REF_9V) begin
      cur_for = CUR_12V;
    end else if (r > REF_5V) begin
      cur_for = CUR_9V;
    end else begin
      cur_for = CUR_5V;
    end
  endfunction : cur_for

  // handshake, request and reference next state
  always_comb begin
    next_state = state;
    next_req_last = req_last;
    next_req_cnt = '0;
    next_ref = voltage_loop_reference;
    next_cont = continuous_mode;
    next_short = line_short;
    next_hv = high_voltage_port_mode;
    // each state sets only what it changes; the defaults above hold the rest and clear req_cnt
    unique case (state)
      ST_PLAIN: begin
        // switch stays closed so the partner sees a plain charging port
        next_short = 1'b1;
        if (plus_up_f) begin
          next_state = ST_WAIT_DM;
          next_short = 1'b0; // opened next edge, well inside 10 ms
        end
      end
      ST_WAIT_DM: begin
        // short removed so the partner's d- pull-down can show
        if (minus_low_f) begin
          next_state = ST_HV;
          next_hv = 1'b1;
          next_req_last = REQ_HOLD;
        end
      end
      ST_HV: begin
        // a new pair restarts the settle count; the count stops once applied,
        // so a steady pair acts only once
        if (req_raw != req_last) begin
          next_req_last = req_raw;
        end else if (req_cnt >= CNT_W'(VCHANGE_CYCLES) - 27'h0000001) begin
          next_req_cnt = req_cnt; // request settled; apply on the first settled cycle
          if (req_cnt == CNT_W'(VCHANGE_CYCLES) - 27'h0000001) begin
            next_req_cnt = req_cnt + 27'h0000001;
            unique case (req_raw)
              REQ_5V: begin next_ref = REF_5V; next_cont = 1'b0; end
              REQ_9V: begin next_ref = REF_9V; next_cont = 1'b0; end
              REQ_12V: begin next_ref = REF_12V; next_cont = 1'b0; end
              // continuous entry keeps the present reference; steps start from it
              REQ_CONT: next_cont = 1'b1;
              REQ_HOLD: ;
            endcase
          end
        end else begin
          next_req_cnt = req_cnt + 27'h0000001;
        end
        // one reference unit per accepted pulse, held inside the range
        // edge-triggered, so a pulse longer than the filter still gives one step
        if (continuous_mode && step_up_f && !step_up_d && voltage_loop_reference < REF_MAX) begin
          next_ref = voltage_loop_reference + REF_STEP;
        end else if (continuous_mode && step_dn_f && !step_dn_d && voltage_loop_reference > REF_MIN) begin
          next_ref = voltage_loop_reference - REF_STEP;
        end
      end
    endcase
    // ground on d+ wins over everything, whatever d- does
    // it also leaves the wait state, so a partner that never answers can retry
    if (plus_gnd_f && state != ST_PLAIN) begin
      next_state = ST_PLAIN;
      next_ref = REF_5V;
      next_cont = 1'b0;
      next_hv = 1'b0;
      next_short = 1'b1;
    end
    // current band from the next reference, so both move on the same edge
    next_cur = cur_for(next_ref);
  end

  // discharge: armed by a downward switch, active while the output is still high
  // only the comparator ends it; a sink held on by a faulty sense is not timed out
  always_comb begin
    next_armed = dis_armed;
    if (next_ref < voltage_loop_reference) begin
      next_armed = 1'b1; // set wins over the clear below
    end else if (dis_armed && !output_above_ref) begin
      next_armed = 1'b0;
    end
    next_dis = next_armed && output_above_ref;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      // power-up: plain port, switch closed, 5V targets
      state <= ST_PLAIN;
      req_last <= REQ_HOLD;
      req_cnt <= '0;
      voltage_loop_reference <= REF_5V;
      current_loop_reference <= CUR_5V;
      continuous_mode <= 1'b0;
      line_short <= 1'b1;
      high_voltage_port_mode <= 1'b0;
      dis_armed <= 1'b0;
      output_discharge <= 1'b0;
      // edge history starts low; edges seen before continuous mode are ignored anyway
      step_up_d <= 1'b0;
      step_dn_d <= 1'b0;
    end else begin
      // every output of the block is taken straight from these flops
      state <= next_state;
      req_last <= next_req_last;
      req_cnt <= next_req_cnt;
      voltage_loop_reference <= next_ref;
      current_loop_reference <= next_cur;
      continuous_mode <= next_cont;
      line_short <= next_short;
      high_voltage_port_mode <= next_hv;
      dis_armed <= next_armed;
      output_discharge <= next_dis;
      step_up_d <= step_up_f;
      step_dn_d <= step_dn_f;
    end
  end
endmodule : cvrd_decoder
`default_nettype wire

/* verif/cvrd_decoder_monitor.sv */
// checker: port-level timing relations of the request decoder
`timescale 1ns/100ps
`default_nettype none
module cvrd_decoder_monitor
  import cvrd_pkg::*;
#(
  parameter int unsigned DETECT_CYCLES = 64,
  parameter int unsigned MINUS_LOW_CYCLES = 16,
  parameter int unsigned VCHANGE_CYCLES = 32,
  parameter int unsigned PLUS_LOW_CYCLES = 24
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic plus_data,
  input wire logic plus_high,
  input wire logic minus_data,
  input wire logic minus_high,
  input wire logic output_above_ref,
  input wire logic line_short,
  input wire logic [REF_W-1:0] voltage_loop_reference,
  input wire logic output_discharge,
  input wire logic high_voltage_port_mode,
  input wire logic continuous_mode
);
  int dp_hi, dp_lo, dm_lo, stab;
  logic [3:0] lines_q;
  // run lengths of line levels; cleared with reset as the filters are
  always_ff @(posedge sys_clk) begin
    dp_hi <= (sys_rst || !plus_data) ? 0 : dp_hi + 1;
    dp_lo <= (sys_rst || plus_data) ? 0 : dp_lo + 1;
    dm_lo <= (sys_rst || minus_data) ? 0 : dm_lo + 1;
    stab <= (sys_rst || lines_q != {plus_data, plus_high, minus_data, minus_high}) ? 0 : stab + 1;
    lines_q <= {plus_data, plus_high, minus_data, minus_high};
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  AST_RESET_VALUES:
    assert property ($fell(sys_rst) |-> voltage_loop_reference == REF_5V && line_short && !high_voltage_port_mode)
      else $error("bad values after reset");
  AST_DETECT_FILTER:
    assert property ($fell(line_short) |-> dp_hi >= DETECT_CYCLES)
      else $error("switch opened before d+ settled");
  AST_HANDSHAKE:
    assert property ($rose(high_voltage_port_mode) |-> !line_short && dm_lo >= MINUS_LOW_CYCLES)
      else $error("handshake accepted too early");
  AST_PLUS_LOW:
    assert property ($fell(high_voltage_port_mode) |-> dp_lo >= PLUS_LOW_CYCLES && line_short
      && voltage_loop_reference == REF_5V)
      else $error("bad line reset");
  AST_FIXED_STABLE:
    assert property ($changed(voltage_loop_reference) && high_voltage_port_mode && $past(high_voltage_port_mode)
      && !continuous_mode |-> stab >= VCHANGE_CYCLES - 1)
      else $error("fixed request applied before settling");
  AST_STEP_SIZE:
    assert property (continuous_mode && $past(continuous_mode) && $changed(voltage_loop_reference) |->
      (voltage_loop_reference == $past(voltage_loop_reference) + REF_STEP
      || voltage_loop_reference == $past(voltage_loop_reference) - REF_STEP) && voltage_loop_reference >= REF_MIN)
      else $error("bad step");
  AST_DISCH_SET:
    assert property ($rose(output_discharge) |-> $past(output_above_ref))
      else $error("discharge without overvoltage");
  AST_DISCH_END:
    assert property (!output_above_ref |=> !output_discharge)
      else $error("discharge kept on");
endmodule : cvrd_decoder_monitor
bind cvrd_decoder cvrd_decoder_monitor #(.DETECT_CYCLES(DETECT_CYCLES), .MINUS_LOW_CYCLES(MINUS_LOW_CYCLES),
  .VCHANGE_CYCLES(VCHANGE_CYCLES), .PLUS_LOW_CYCLES(PLUS_LOW_CYCLES)) u_mon (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .plus_data(plus_data), .plus_high(plus_high), .minus_data(minus_data),
  .minus_high(minus_high), .output_above_ref(output_above_ref), .line_short(line_short),
  .voltage_loop_reference(voltage_loop_reference), .output_discharge(output_discharge),
  .high_voltage_port_mode(high_voltage_port_mode), .continuous_mode(continuous_mode));
`default_nettype wire

/* verif/cvrd_pd_model.sv */
// partner model: portable device setting d+ and d- levels
`timescale 1ns/100ps
`default_nettype none
module cvrd_pd_model (
  input wire logic [1:0] dp_lvl, // 0 ground, 1 near 0.6 v, 2 near 3.3 v
  input wire logic [1:0] dm_lvl,
  input wire logic line_short,
  output logic plus_data,
  output logic plus_high,
  output logic minus_data,
  output logic minus_high
);
  logic [1:0] dm_wire;
  // a closed switch ties d- to d+, overriding our own d- level
  assign dm_wire = line_short ? dp_lvl : dm_lvl;
  assign plus_data = dp_lvl != 2'h0;
  assign plus_high = dp_lvl == 2'h2;
  assign minus_data = dm_wire != 2'h0;
  assign minus_high = dm_wire == 2'h2;
endmodule : cvrd_pd_model
`default_nettype wire

/* verif/test_charger_voltage_request_decoder.sv */
// testbench: handshake, fixed requests, stepping and line reset
`timescale 1ns/100ps
`default_nettype none
module test_charger_voltage_request_decoder;
  import cvrd_pkg::*;
  localparam int DET = 64, MLO = 16, VCH = 32, PLO = 24, STP = 8;
  localparam logic [1:0] G = 2'h0, L = 2'h1, H = 2'h2;
  logic sys_clk = 1'b0, sys_rst = 1'b1, above = 1'b0;
  logic [1:0] dp = G, dm = G;
  logic pd, ph, md, mh, sh, dis, hv, cont;
  logic [REF_W-1:0] vref;
  cvrd_cur_t cur;
  int n_fail = 0, total_checks = 0;
  cvrd_decoder #(.DETECT_CYCLES(DET), .MINUS_LOW_CYCLES(MLO), .VCHANGE_CYCLES(VCH), .PLUS_LOW_CYCLES(PLO),
    .STEP_CYCLES(STP)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .plus_data(pd), .plus_high(ph),
    .minus_data(md), .minus_high(mh), .output_above_ref(above), .line_short(sh), .voltage_loop_reference(vref),
    .current_loop_reference(cur), .output_discharge(dis), .high_voltage_port_mode(hv), .continuous_mode(cont));
  cvrd_pd_model PD (.dp_lvl(dp), .dm_lvl(dm), .line_short(sh), .plus_data(pd), .plus_high(ph),
    .minus_data(md), .minus_high(mh));
  initial forever #12.5 sys_clk = ~sys_clk;
  // inputs always move 2 ns after an edge, never on it
  task automatic wc(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : wc
  task automatic ck(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : ck
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  // d+ at 0.6 until detection, then the opened switch lets d- fall
  task automatic t_hand;
    dp = L;
    dm = G;
    wc(DET - 4);
    ck(sh === 1'b1, "switch opened early");
    wc(8);
    ck(sh === 1'b0 && hv === 1'b0 && vref === REF_5V, "detect");
    wc(MLO - 4);
    ck(hv === 1'b0, "d- low taken early");
    wc(6);
    ck(hv === 1'b1 && vref === REF_5V, "handshake");
    $display("handshake test done");
  endtask : t_hand
  task automatic t_fixed;
    logic [1:0] tp[6] = '{H, L, H, H, H, L};
    logic [1:0] tm[6] = '{L, L, H, G, L, G};
    logic [REF_W-1:0] tv[6] = '{REF_9V, REF_12V, REF_12V, REF_12V, REF_9V, REF_5V};
    cvrd_cur_t tc[6] = '{CUR_9V, CUR_12V, CUR_12V, CUR_12V, CUR_9V, CUR_5V};
    logic [REF_W-1:0] pv = REF_5V;
    above = 1'b1;
    for (int i = 0; i < 6; i++) begin
      dp = tp[i];
      dm = tm[i];
      wc(VCH / 2);
      ck(vref === pv, "applied early");
      wc(VCH / 2 + 4);
      ck(vref === tv[i] && cur === tc[i], "decode");
      ck(dis === (tv[i] < pv), "discharge on");
      above = 1'b0;
      wc(2);
      ck(dis === 1'b0, "discharge off");
      above = 1'b1;
      pv = tv[i];
    end
    $display("fixed test done");
  endtask : t_fixed
  // one step pulse, then a gap; widths scaled like the filters
  task automatic pulse(input logic up, input int w);
    if (up) dp = H;
    else dm = L;
    wc(w);
    dp = L;
    dm = H;
    wc(2 * STP);
  endtask : pulse
  task automatic t_cont;
    dp = L;
    dm = H;
    wc(VCH + 4);
    ck(cont === 1'b1 && vref === REF_5V, "continuous entry");
    pulse(1'b1, STP - 3);
    ck(vref === REF_5V, "short pulse taken");
    pulse(1'b1, STP + 2);
    ck(vref === REF_5V + REF_STEP, "step up");
    for (int i = 0; i < 9; i++) begin
      pulse(1'b0, STP + 2);
      ck(vref === ((i < 8) ? REF_5V - 7'(i) : REF_MIN), "step down");
    end
    $display("continuous test done");
  endtask : t_cont
  task automatic t_line;
    dp = G;
    wc(PLO / 2);
    ck(hv === 1'b1, "d+ low taken early");
    wc(PLO / 2 + 4);
    ck(hv === 1'b0 && cont === 1'b0 && sh === 1'b1 && vref === REF_5V && cur === CUR_5V, "line reset");
    $display("line reset test done");
  endtask : t_line
  initial begin
    wc(5);
    sys_rst = 1'b0;
    t_hand();
    t_fixed();
    t_cont();
    t_line();
    t_hand();
    wrap_up();
  end
  // the run needs about 750 cycles
  initial begin
    repeat (4000) @(posedge sys_clk);
    n_fail++;
    wrap_up();
  end
endmodule : test_charger_voltage_request_decoder
`default_nettype wire
